// ===== core/rceb_elastic.sv
// Receive elasticity buffer held in flip-flops.
// Assumes push and pop are single-cycle strobes on mclk.
`timescale 1ns/1ps
module rceb_elastic #(
   parameter int W     = 2,
   parameter int DEPTH = 16,
   parameter int LVW   = 5
) (
   input  wire logic  mclk,
   input  wire logic  rst_n,
   rceb_fifo_if.buf_side f
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0]   mem_q [DEPTH];
   logic [W-1:0]   mem_d [DEPTH];
   logic [AW-1:0]  wr_q, wr_d, rd_q, rd_d;
   logic [LVW-1:0] lvl_q, lvl_d;
   logic [W-1:0]   out_q, out_d;
   logic           do_push, do_pop;

   // Push into a full buffer or pop from an empty one is refused and flagged
   assign f.full     = (lvl_q == LVW'(DEPTH));
   assign f.empty    = (lvl_q == '0);
   assign do_push    = f.push & ~f.full;
   assign do_pop     = f.pop & ~f.empty;
   assign f.ovf      = f.push & f.full;
   assign f.udf      = f.pop & f.empty;
   assign f.level    = lvl_q;
   assign f.pop_data = out_q;

   // Pointer and level update; flush drops what is left of a frame
   always_comb begin
      mem_d = mem_q;
      wr_d  = wr_q;
      rd_d  = rd_q;
      out_d = out_q;
      lvl_d = lvl_q;
      if (do_push) begin
         mem_d[wr_q] = f.push_data;
         wr_d        = AW'((int'(wr_q) + 1) % DEPTH);
      end
      if (do_pop) begin
         out_d = mem_q[rd_q];
         rd_d  = AW'((int'(rd_q) + 1) % DEPTH);
      end
      lvl_d = LVW'(int'(lvl_q) + int'(do_push) - int'(do_pop));
      if (f.flush) begin
         wr_d  = '0;
         rd_d  = '0;
         lvl_d = '0;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= '0;
         end
         wr_q  <= '0;
         rd_q  <= '0;
         lvl_q <= '0;
         out_q <= '0;
      end else begin
         mem_q <= mem_d;
         wr_q  <= wr_d;
         rd_q  <= rd_d;
         lvl_q <= lvl_d;
         out_q <= out_d;
      end
   end
endmodule

// ===== core/rceb_fifo_if.sv
// Push/pop connection between the control block and its elastic buffer.
// Assumes both ends run on mclk.
`timescale 1ns/1ps
interface rceb_fifo_if #(
   parameter int W   = 2,
   parameter int LVW = 5
);
   logic           push;
   logic [W-1:0]   push_data;
   logic           pop;
   logic [W-1:0]   pop_data;
   logic [LVW-1:0] level;
   logic           full;
   logic           empty;
   logic           ovf;
   logic           udf;
   logic           flush;
   modport ctrl (output push, push_data, pop, flush,
                 input pop_data, level, full, empty, ovf, udf);
   modport buf_side (input push, push_data, pop, flush,
                     output pop_data, level, full, empty, ovf, udf);
endinterface

// ===== core/rceb_pkg.sv
// Constants shared by the RMII control/status block and its elastic buffer.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
package rceb_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0]  RCS_IDX      = 8'h17;
   localparam logic [7:0]  IRQ_ST_IDX   = 8'h20;
   localparam logic [7:0]  IRQ_MSK_IDX  = 8'h21;
   localparam int          ADDR_W       = 10;
   localparam logic [15:0] RCS_RESET    = 16'h0041;
   // Control/status field positions
   localparam int TX_SHIFT_BIT = 8;
   localparam int CLK_SEL_BIT  = 7;
   localparam int RSV_ONE_BIT  = 6;
   localparam int RSV_STR_BIT  = 5;
   localparam int REV_SEL_BIT  = 4;
   localparam int OVF_BIT      = 3;
   localparam int UDF_BIT      = 2;
   localparam int SIZE_LSB     = 0;
   localparam int SIZE_MSB     = 1;
   // Interrupt status layout
   localparam int IRQ_OVF_BIT  = 0;
   localparam int IRQ_UDF_BIT  = 1;
   localparam int IRQ_W        = 2;
   // Tolerance in bits per elasticity code
   localparam int TOL_BITS_0   = 14;
   localparam int TOL_BITS_1   = 2;
   localparam int TOL_BITS_2   = 6;
   localparam int TOL_BITS_3   = 10;
   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Cycles after reset release before the strap is trusted
   localparam logic [1:0] STRAP_WAIT  = 2'h3;
   typedef enum logic [1:0] {
      RCEB_IDLE  = 2'b00,
      RCEB_FILL  = 2'b01,
      RCEB_DRAIN = 2'b10
   } rceb_state_t;
endpackage

// ===== core/rceb_top.sv
// RMII control/status register with receive elasticity buffer.
// Assumes line-side receive dibits arrive on mclk; ref_clk, straps and
// the slave-mode pin are asynchronous and are synchronised here.
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module rceb_top #(
   parameter int DEPTH = 16
) (
   input  wire logic                      mclk,
   input  wire logic                      rst_n,
   input  wire logic [rceb_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                      s_axi_awvalid,
   output logic                           s_axi_awready,
   input  wire logic [31:0]               s_axi_wdata,
   input  wire logic [3:0]                s_axi_wstrb,
   input  wire logic                      s_axi_wvalid,
   output logic                           s_axi_wready,
   output logic [1:0]                     s_axi_bresp,
   output logic                           s_axi_bvalid,
   input  wire logic                      s_axi_bready,
   input  wire logic [rceb_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic                      s_axi_arvalid,
   output logic                           s_axi_arready,
   output logic [31:0]                    s_axi_rdata,
   output logic [1:0]                     s_axi_rresp,
   output logic                           s_axi_rvalid,
   input  wire logic                      s_axi_rready,
   input  wire logic                      line_dv,
   input  wire logic [1:0]                line_rxd,
   input  wire logic                      line_crs,
   input  wire logic                      ref_clk,
   input  wire logic                      clk_sel_strap,
   input  wire logic                      rmii_slave_mode,
   output logic                           crs_dv,
   output logic [1:0]                     rxd,
   output logic                           tx_clk_shift_en,
   output logic                           ref_clk_50m_sel,
   output logic                           irq
);
   localparam int LVW = $clog2(DEPTH) + 1;
   localparam logic [rceb_pkg::ADDR_W-1:0] A_RCS =
      rceb_pkg::ADDR_W'({rceb_pkg::RCS_IDX, 2'b00});
   localparam logic [rceb_pkg::ADDR_W-1:0] A_IST =
      rceb_pkg::ADDR_W'({rceb_pkg::IRQ_ST_IDX, 2'b00});
   localparam logic [rceb_pkg::ADDR_W-1:0] A_IMSK =
      rceb_pkg::ADDR_W'({rceb_pkg::IRQ_MSK_IDX, 2'b00});

   // Start threshold in dibits: half the tolerance, so drift either way fits
   function automatic logic [LVW-1:0] start_level(input logic [1:0] code);
      int bits;
      case (code)
         2'h0:    bits = rceb_pkg::TOL_BITS_0;
         2'h1:    bits = rceb_pkg::TOL_BITS_1;
         2'h2:    bits = rceb_pkg::TOL_BITS_2;
         default: bits = rceb_pkg::TOL_BITS_3;
      endcase
      return LVW'(bits / 2);
   endfunction

   rceb_fifo_if #(.W(2), .LVW(LVW)) fif ();

   rceb_elastic #(.W(2), .DEPTH(DEPTH), .LVW(LVW)) u_buf (
      .mclk  (mclk),
      .rst_n (rst_n),
      .f     (fif)
   );

   // Pin synchronisers; only the second stage feeds logic, plus the third stage of ref_clk for edge detection
   logic [2:0] rclk_q;
   logic [1:0] strap_q, slave_q;
   logic       link_edge;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rclk_q  <= '0;
         strap_q <= '0;
         slave_q <= '0;
      end else begin
         rclk_q  <= {rclk_q[1:0], ref_clk};
         strap_q <= {strap_q[0], clk_sel_strap};
         slave_q <= {slave_q[0], rmii_slave_mode};
      end
   end
   assign link_edge = rclk_q[1] & ~rclk_q[2];

   // Register state
   logic [15:0]      rcs_q, rcs_d;
   logic [1:0]       boot_q, boot_d;
   logic             ovf_q, ovf_d, udf_q, udf_d, live_q, live_d;
   logic [rceb_pkg::IRQ_W-1:0] ist_q, ist_d, imsk_q, imsk_d;
   // AXI state
   logic             aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
   logic [rceb_pkg::ADDR_W-1:0] awa_q, awa_d;
   logic [31:0]      wd_q, wd_d, rd_q, rd_d;
   logic [3:0]       ws_q, ws_d;
   logic [1:0]       br_q, br_d, rr_q, rr_d;
   logic [15:0]      rcs_view, wmask, wbits;
   logic             do_wr, do_rd;
   // Receive path state
   rceb_pkg::rceb_state_t st_q, st_d;
   logic             cdv_q, cdv_d, popd_q, popd_d, tog_q, tog_d;
   logic [1:0]       rxd_q, rxd_d;

   // Status bits read zero until the buffer has carried a frame
   always_comb begin
      rcs_view = rcs_q;
      rcs_view[rceb_pkg::OVF_BIT] = live_q & ~ovf_q;
      rcs_view[rceb_pkg::UDF_BIT] = live_q & ~udf_q;
   end

   assign s_axi_awready = ~aw_q & ~bv_q;
   assign s_axi_wready  = ~w_q & ~bv_q;
   assign s_axi_arready = ~rv_q;
   assign do_wr = aw_q & w_q & ~bv_q;
   assign do_rd = s_axi_arvalid & ~rv_q;
   assign wmask = {{8{ws_q[1]}}, {8{ws_q[0]}}};
   assign wbits = (rcs_q & ~wmask) | (wd_q[15:0] & wmask);

   // Bus slave and register next state
   always_comb begin
      aw_d = aw_q; awa_d = awa_q; w_d = w_q; wd_d = wd_q; ws_d = ws_q;
      bv_d = bv_q; br_d = br_q; rv_d = rv_q; rd_d = rd_q; rr_d = rr_q;
      rcs_d = rcs_q; boot_d = boot_q; imsk_d = imsk_q;
      live_d = live_q | (st_q == rceb_pkg::RCEB_DRAIN);
      if (s_axi_awvalid && s_axi_awready) begin
         aw_d  = 1'b1;
         awa_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_d  = 1'b1;
         wd_d = s_axi_wdata;
         ws_d = s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
         bv_d = 1'b0;
      end
      if (s_axi_rvalid && s_axi_rready) begin
         rv_d = 1'b0;
      end
      // Strap is caught once its synchroniser has settled after reset
      if (boot_q != rceb_pkg::STRAP_WAIT) begin
         boot_d = boot_q + 2'h1;
         if (boot_d == rceb_pkg::STRAP_WAIT) begin
            rcs_d[rceb_pkg::CLK_SEL_BIT] = strap_q[1];
         end
      end
      if (do_wr) begin
         aw_d = 1'b0;
         w_d  = 1'b0;
         bv_d = 1'b1;
         br_d = rceb_pkg::RESP_OKAY;
         if (awa_q == A_RCS) begin
            // Status bits are not writable; the rest of bits 8 to 0 is plain R/W, bits 15 to 9 stay zero
            rcs_d[rceb_pkg::TX_SHIFT_BIT:rceb_pkg::SIZE_LSB] =
               wbits[rceb_pkg::TX_SHIFT_BIT:rceb_pkg::SIZE_LSB];
            rcs_d[rceb_pkg::OVF_BIT] = 1'b0;
            rcs_d[rceb_pkg::UDF_BIT] = 1'b0;
         end else if (awa_q == A_IMSK) begin
            if (ws_q[0]) begin
               imsk_d = wd_q[rceb_pkg::IRQ_W-1:0];
            end
         end else if (awa_q != A_IST) begin
            br_d = rceb_pkg::RESP_SLVERR;
         end
      end
      if (do_rd) begin
         rv_d = 1'b1;
         rr_d = rceb_pkg::RESP_OKAY;
         rd_d = '0;
         case (s_axi_araddr)
            A_RCS:   rd_d = {16'h0000, rcs_view};
            A_IST:   rd_d = 32'(ist_q);
            A_IMSK:  rd_d = 32'(imsk_q);
            default: rr_d = rceb_pkg::RESP_SLVERR;
         endcase
      end
   end

   // Sticky flags: a read clears them, a same-cycle event wins
   always_comb begin
      ovf_d = ovf_q;
      udf_d = udf_q;
      ist_d = ist_q;
      if (do_rd && s_axi_araddr == A_RCS) begin
         ovf_d = 1'b0;
         udf_d = 1'b0;
      end
      if (do_rd && s_axi_araddr == A_IST) begin
         ist_d = '0;
      end
      if (fif.ovf) begin
         ovf_d = 1'b1;
         ist_d[rceb_pkg::IRQ_OVF_BIT] = 1'b1;
      end
      if (fif.udf) begin
         udf_d = 1'b1;
         ist_d[rceb_pkg::IRQ_UDF_BIT] = 1'b1;
      end
   end

   // Receive drain: fill to half tolerance, then pop one dibit per edge
   assign fif.push      = line_dv;
   assign fif.push_data = line_rxd;
   always_comb begin
      st_d   = st_q;
      cdv_d  = cdv_q;
      tog_d  = tog_q;
      rxd_d  = rxd_q;
      popd_d = 1'b0;
      fif.pop   = 1'b0;
      fif.flush = 1'b0;
      case (st_q)
         rceb_pkg::RCEB_IDLE: begin
            cdv_d = 1'b0;
            if (line_dv) begin
               st_d = rceb_pkg::RCEB_FILL;
            end
         end
         rceb_pkg::RCEB_FILL: begin
            if (fif.level >= start_level(rcs_q[rceb_pkg::SIZE_MSB:
                                               rceb_pkg::SIZE_LSB])) begin
               st_d  = rceb_pkg::RCEB_DRAIN;
               tog_d = 1'b0;
            end else if (!line_crs) begin
               // Carrier gone below the start level: drain what is held
               st_d  = fif.empty ? rceb_pkg::RCEB_IDLE : rceb_pkg::RCEB_DRAIN;
               tog_d = 1'b0;
            end
         end
         rceb_pkg::RCEB_DRAIN: begin
            if (link_edge) begin
               if (line_crs || !fif.empty) begin
                  fif.pop = 1'b1;
                  popd_d  = 1'b1;
                  tog_d   = ~tog_q;
                  if (line_crs) begin
                     cdv_d = 1'b1;
                  end else if (rcs_q[rceb_pkg::REV_SEL_BIT]) begin
                     cdv_d = 1'b1;
                  end else begin
                     cdv_d = tog_q;
                  end
               end else begin
                  // Last dibit is out; frame is over
                  cdv_d     = 1'b0;
                  st_d      = rceb_pkg::RCEB_IDLE;
                  fif.flush = 1'b1;
               end
            end
         end
         default: begin
            st_d = rceb_pkg::RCEB_IDLE;
         end
      endcase
      if (popd_q) begin
         rxd_d = fif.pop_data;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rcs_q  <= rceb_pkg::RCS_RESET;
         boot_q <= '0;
         ovf_q  <= 1'b0;
         udf_q  <= 1'b0;
         live_q <= 1'b0;
         ist_q  <= '0;
         imsk_q <= '0;
         aw_q   <= 1'b0;
         awa_q  <= '0;
         w_q    <= 1'b0;
         wd_q   <= '0;
         ws_q   <= '0;
         bv_q   <= 1'b0;
         br_q   <= rceb_pkg::RESP_OKAY;
         rv_q   <= 1'b0;
         rd_q   <= '0;
         rr_q   <= rceb_pkg::RESP_OKAY;
         st_q   <= rceb_pkg::RCEB_IDLE;
         cdv_q  <= 1'b0;
         tog_q  <= 1'b0;
         popd_q <= 1'b0;
         rxd_q  <= '0;
      end else begin
         rcs_q  <= rcs_d;
         boot_q <= boot_d;
         ovf_q  <= ovf_d;
         udf_q  <= udf_d;
         live_q <= live_d;
         ist_q  <= ist_d;
         imsk_q <= imsk_d;
         aw_q   <= aw_d;
         awa_q  <= awa_d;
         w_q    <= w_d;
         wd_q   <= wd_d;
         ws_q   <= ws_d;
         bv_q   <= bv_d;
         br_q   <= br_d;
         rv_q   <= rv_d;
         rd_q   <= rd_d;
         rr_q   <= rr_d;
         st_q   <= st_d;
         cdv_q  <= cdv_d;
         tog_q  <= tog_d;
         popd_q <= popd_d;
         rxd_q  <= rxd_d;
      end
   end

   // Outputs; shift applies only when strapped as RMII slave
   assign s_axi_bvalid    = bv_q;
   assign s_axi_bresp     = br_q;
   assign s_axi_rvalid    = rv_q;
   assign s_axi_rdata     = rd_q;
   assign s_axi_rresp     = rr_q;
   assign crs_dv          = cdv_q;
   assign rxd             = rxd_q;
   assign tx_clk_shift_en = rcs_q[rceb_pkg::TX_SHIFT_BIT] & slave_q[1];
   assign ref_clk_50m_sel = rcs_q[rceb_pkg::CLK_SEL_BIT];
   assign irq             = |(ist_q & imsk_q);
endmodule

// ===== tb/rceb_mac_model.sv
// Behavioural MAC on the receive side of the RMII link.
// Assumes a free-running reference oscillator feeds both ends.
`timescale 1ns/1ps
module rceb_mac_model (
   output logic            ref_clk,
   input  wire logic       crs_dv,
   input  wire logic [1:0] rxd
);
   int         rises;
   logic       last;
   logic [1:0] got[$];
   // Reference runs free, offset so it never meets an mclk edge
   initial begin
      ref_clk = 1'b0;
      last = 1'b0;
      rises = 0;
      #37;
      forever #400 ref_clk = ~ref_clk;
   end
   // Sample the pins on each rising reference edge, as a MAC does
   always @(posedge ref_clk) begin
      if (crs_dv && !last) rises++;
      if (crs_dv) got.push_back(rxd);
      last = crs_dv;
   end
endmodule

// ===== tb/rceb_top_properties.sv
// Port-level properties of the RMII control block.
// Assumes one mclk domain; bound to every rceb_top instance.
`timescale 1ns/1ps
module rceb_top_chk (
   input wire logic        mclk,
   input wire logic        rst_n,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        ref_clk,
   input wire logic        rmii_slave_mode,
   input wire logic        crs_dv,
   input wire logic [1:0]  rxd,
   input wire logic        tx_clk_shift_en
);
   logic       ref_q;
   logic [3:0] age_q;
   logic [3:0] age_d;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   // Cycles since the raw link clock was seen rising, saturating
   always_comb begin
      age_d = age_q + {3'h0, age_q != 4'hF};
      if (ref_clk && !ref_q) begin
         age_d = 4'h0;
      end
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ref_q <= 1'b0;
         age_q <= 4'hF;
      end else begin
         ref_q <= ref_clk;
         age_q <= age_d;
      end
   end
   // Write address and data taken together, then the answer
   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_resp_up;
      s_axi_bvalid;
   endsequence
   property p_b_answer;
      s_wr_taken |-> ##2 s_resp_up;
   endproperty
   a_b_answer: assert property (p_b_answer)
      else $error("write response not two cycles after transfer");
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold)
      else $error("write response dropped before bready");
   property p_r_answer;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_r_answer: assert property (p_r_answer)
      else $error("read data not one cycle after address");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold)
      else $error("read data changed before rready");
   // The register is 16 bits wide; upper lanes always read zero
   property p_upper_zero;
      s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000;
   endproperty
   a_upper_zero: assert property (p_upper_zero)
      else $error("read data upper half not zero");
   // Shift only applies as a slave; allows two sync stages plus output
   property p_shift_off;
      !rmii_slave_mode [*4] |=> !tx_clk_shift_en;
   endproperty
   a_shift_off: assert property (p_shift_off)
      else $error("transmit clock shift active outside slave mode");
   // Receive pins move only just after a link clock edge
   property p_crs_pace;
      $changed(crs_dv) |-> age_q <= 4'h5;
   endproperty
   a_crs_pace: assert property (p_crs_pace)
      else $error("crs_dv moved away from a link clock edge");
   property p_rxd_pace;
      $changed(rxd) |-> age_q <= 4'h5;
   endproperty
   a_rxd_pace: assert property (p_rxd_pace)
      else $error("rxd moved away from a link clock edge");
endmodule
bind rceb_top rceb_top_chk u_chk (
   .mclk, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
   .s_axi_rready, .ref_clk, .rmii_slave_mode, .crs_dv, .rxd,
   .tx_clk_shift_en
);

// ===== tb/rmii_config_elastic_buffer_bench.sv
// Self-checking bench for the RMII control block and elastic buffer.
// Assumes the MAC model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module rmii_config_elastic_buffer_bench;
   localparam logic [9:0] CTRL = {rceb_pkg::RCS_IDX, 2'b00};
   localparam logic [9:0] IST  = {rceb_pkg::IRQ_ST_IDX, 2'b00};
   localparam logic [9:0] IMSK = {rceb_pkg::IRQ_MSK_IDX, 2'b00};
   localparam logic [1:0] OK   = rceb_pkg::RESP_OKAY;
   localparam logic [1:0] SE   = rceb_pkg::RESP_SLVERR;
   logic        mclk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic        s_axi_arready, s_axi_rvalid, s_axi_rready, line_dv;
   logic        line_crs, ref_clk, clk_sel_strap, rmii_slave_mode, crs_dv;
   logic        tx_clk_shift_en, ref_clk_50m_sel, irq;
   logic [9:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, data;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, line_rxd, rxd, resp;
   int          err_total, check_count, cyc;

   rceb_top #(.DEPTH(16)) DUT (
      .mclk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .line_dv, .line_rxd, .line_crs,
      .ref_clk, .clk_sel_strap, .rmii_slave_mode, .crs_dv, .rxd,
      .tx_clk_shift_en, .ref_clk_50m_sel, .irq
   );
   rceb_mac_model u_mac (.ref_clk, .crs_dv, .rxd);

   always #50 mclk = ~mclk;

   task automatic tally_and_finish();
      if (err_total == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // Hang guard: the whole sequence needs about a thousand cycles
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         tally_and_finish();
      end
   end

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         err_total++;
         $display("Error t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   // Ready is looked at mid-cycle, where it is settled for the next edge
   task automatic wr(input logic [9:0] a, input logic [31:0] d,
                     input logic [1:0] er);
      logic ta, tw, tb;
      @(posedge mclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(negedge mclk);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         tb = s_axi_bvalid;
         resp = s_axi_bresp;
         @(posedge mclk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
      end while (!tb);
      s_axi_bready <= 1'b0;
      chk({30'h0, resp}, {30'h0, er});
   endtask

   task automatic rd(input logic [9:0] a, input logic [31:0] e,
                     input logic [1:0] er);
      logic ta, tr;
      @(posedge mclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(negedge mclk);
         ta = s_axi_arvalid && s_axi_arready;
         tr = s_axi_rvalid;
         data = s_axi_rdata;
         resp = s_axi_rresp;
         @(posedge mclk);
         if (ta) s_axi_arvalid <= 1'b0;
      end while (!tr);
      s_axi_rready <= 1'b0;
      chk(data, e);
      chk({30'h0, resp}, {30'h0, er});
   endtask

   // Short frames, far under the shortest supported length
   task automatic frame(input int n, input int hold);
      int idle;
      u_mac.got.delete();
      u_mac.rises = 0;
      for (int i = 0; i <= n; i++) begin
         @(posedge mclk);
         line_crs <= 1'b1;
         line_dv <= (i < n);
         line_rxd <= i[1:0];
      end
      repeat (hold + 1) @(posedge mclk);
      line_crs <= 1'b0;
      idle = 0;
      while (idle < 24) begin
         @(negedge mclk);
         idle = crs_dv ? 0 : idle + 1;
      end
   endtask

   // Main sequence; control writes always keep reserved bit 6 set
   initial begin
      mclk = 1'b0;
      {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid,
       s_axi_rready, line_dv, line_crs, rmii_slave_mode} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, line_rxd} = '0;
      s_axi_wstrb = 4'hF;
      clk_sel_strap = 1'b1;
      err_total = 0;
      check_count = 0;
      cyc = 0;
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (8) @(negedge mclk);
      chk({31'h0, ref_clk_50m_sel}, 32'h1);
      rd(CTRL, {16'h0, rceb_pkg::RCS_RESET} | 32'h80, OK);
      wr(CTRL, 32'h0041, OK);
      rd(CTRL, 32'h0041, OK);
      @(negedge mclk);
      chk({31'h0, ref_clk_50m_sel}, 32'h0);
      rd(10'h3F0, 32'h0, SE);
      wr(10'h3F0, 32'hFFFF, SE);
      wr(CTRL, 32'h0141, OK);
      repeat (6) @(negedge mclk);
      chk({31'h0, tx_clk_shift_en}, 32'h0);
      @(posedge mclk);
      rmii_slave_mode <= 1'b1;
      repeat (6) @(negedge mclk);
      chk({31'h0, tx_clk_shift_en}, 32'h1);
      rd(CTRL, 32'h0141, OK);
      wr(IMSK, 32'h3, OK);
      rd(IMSK, 32'h3, OK);
      wr(CTRL, 32'h0051, OK);
      frame(12, 0);
      chk(u_mac.got.size(), 32'd12);
      for (int i = 0; i < 12; i++)
         chk({30'h0, u_mac.got[i]}, i & 3);
      chk(u_mac.rises, 32'd1);
      rd(CTRL, 32'h005D, OK);
      wr(CTRL, 32'h0041, OK);
      frame(12, 0);
      chk({31'h0, u_mac.rises > 1}, 32'h1);
      wr(CTRL, 32'h0040, OK);
      frame(24, 0);
      @(negedge mclk);
      chk({31'h0, irq}, 32'h1);
      rd(CTRL, 32'h0044, OK);
      wr(IMSK, 32'h0, OK);
      @(negedge mclk);
      chk({31'h0, irq}, 32'h0);
      wr(IMSK, 32'h3, OK);
      @(negedge mclk);
      chk({31'h0, irq}, 32'h1);
      rd(IST, 32'h1, OK);
      @(negedge mclk);
      chk({31'h0, irq}, 32'h0);
      wr(CTRL, 32'h0041, OK);
      frame(2, 40);
      rd(CTRL, 32'h0049, OK);
      rd(IST, 32'h2, OK);
      // Short frame under a long carrier: waits below the start level,
      // drains after carrier drop, so no underflow unlike code 1
      wr(CTRL, 32'h0052, OK);
      frame(2, 40);
      chk(u_mac.got.size(), 32'd2);
      rd(CTRL, 32'h005E, OK);
      wr(CTRL, 32'h0053, OK);
      frame(4, 40);
      chk(u_mac.got.size(), 32'd4);
      rd(CTRL, 32'h005F, OK);
      for (int k = 0; k < 4; k++) begin
         wr(CTRL, 32'h0040 | k, OK);
         rd(CTRL, 32'h004C | k, OK);
      end
      tally_and_finish();
   end
endmodule
